// ===== bench/irq_source_model.sv
// Model of the external interrupt pins and peripheral event strobes
`default_nettype none
module irq_source_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] strobe_cmd,
  input  wire logic [4:0] pin_cmd,
  output logic      [7:0] strobe,
  output logic      [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cmd_q;

  // Previous request level, so a held request still gives one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 8'h00;
    end else begin
      cmd_q <= strobe_cmd;
    end
  end

  // Peripherals strobe for one cycle only; pins idle high as if pulled up
  assign strobe = strobe_cmd & ~cmd_q;
  assign pin    = pin_cmd;
endmodule // irq_source_model
`default_nettype wire

// ===== bench/tb_irq_flag_logic.sv
// Self-checking testbench for the interrupt flag block
`include "irq_flag_regs.svh"
`default_nettype none
module tb_irq_flag_logic
  import irq_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  strobe_cmd;
  logic [4:0]  pin_cmd;
  logic [7:0]  strobe;
  logic [4:0]  pin;
  logic        conv_busy;
  logic        f8_mode;
  logic        analog_ch3_select;
  logic        timer_c_event_input;
  logic        timer_f_event_input;
  logic        conversion_trigger_input;
  logic        irq_out;
  reg8_t       rd;
  logic        err;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cnt_c = 0;
  int          cnt_f = 0;
  int          cnt_t = 0;

  // Free-running 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  irq_source_model irq_source_model_i (.pclk(pclk), .presetn(presetn), .strobe_cmd(strobe_cmd),
    .pin_cmd(pin_cmd), .strobe(strobe), .pin(pin));

  irq_flag_logic irq_flag_logic_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin0(pin[0]), .port_b_pin3(pin[1]), .event_counter_irq_pin(pin[2]), .irq_pin3(pin[3]),
    .irq_pin4(pin[4]), .timer_a_overflow(strobe[0]), .event_counter_overflow(strobe[1]),
    .timer_c_overflow(strobe[2]), .timer_c_underflow(strobe[3]), .timer_f_low_match(strobe[4]),
    .timer_f_high_match(strobe[5]), .timer_g_event(strobe[6]), .direct_transition(strobe[7]),
    .timer_f_8bit_mode(f8_mode), .conversion_start_flag(conv_busy), .analog_ch3_select(analog_ch3_select),
    .timer_c_event_input(timer_c_event_input), .timer_f_event_input(timer_f_event_input),
    .conversion_trigger_input(conversion_trigger_input), .irq_out(irq_out));

  // Shared timer and trigger pulses are counted to check which edges reach them
  always @(posedge pclk) begin
    if (timer_c_event_input === 1'b1) cnt_c <= cnt_c + 1;
    if (timer_f_event_input === 1'b1) cnt_f <= cnt_f + 1;
    if (conversion_trigger_input === 1'b1) cnt_t <= cnt_t + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_byte(input string what, input reg8_t exp, input reg8_t got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // One APB transfer; race raises peripheral strobes during the access cycle
  task automatic apb(input logic wr, input logic [11:0] a, input reg8_t wd, input reg8_t race);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable    <= 1'b1;
    strobe_cmd <= race;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd  = prdata[7:0];
    err = pslverr;
    psel       <= 1'b0;
    penable    <= 1'b0;
    strobe_cmd <= 8'h00;
    if (pready !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input reg8_t wd);
    apb(1'b1, ba(idx), wd, 8'h00);
  endtask

  task automatic chk_reg(input string what, input logic [7:0] idx, input reg8_t exp);
    apb(1'b0, ba(idx), 8'h00, 8'h00);
    cmp_byte(what, exp, rd);
  endtask

  task automatic pulse(input reg8_t m);
    strobe_cmd <= m;
    @(posedge pclk);
    strobe_cmd <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask

  // Pins must settle through the synchroniser before the flag shows
  task automatic pins(input logic [4:0] v);
    pin_cmd <= v;
    repeat (8) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    cmp_bit("irq_out", 1'b0, irq_out);
    cmp_bit("analog_ch3_select", 1'b1, analog_ch3_select);
    chk_reg("port_b_function_reg", `IDX_PORT_B_FUNC, `PORT_B_FIXED);
    chk_reg("edge_select", `IDX_EDGE_SELECT, `EDGE_SEL_FIXED);
    chk_reg("flags_one", `IDX_FLAGS_ONE, `FLAGS_ONE_FIXED);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h00);
    chk_reg("mask_one", `IDX_MASK_ONE, 8'h00);
    chk_reg("mask_two", `IDX_MASK_TWO, 8'h00);
    chk_reg("pin_enable", `IDX_PIN_ENABLE, 8'h00);
    apb(1'b0, ba(8'hf3), 8'h00, 8'h00);
    cmp_bit("unmapped error", 1'b1, err);
    cmp_byte("unmapped data", 8'h00, rd);
    apb(1'b1, 12'h3d9, 8'h00, 8'h00);
    cmp_bit("misaligned error", 1'b1, err);
    wr(`IDX_EDGE_SELECT, 8'h9b);
    chk_reg("edge_select", `IDX_EDGE_SELECT, 8'hff);
  endtask

  task automatic s_strobes();
    f8_mode <= 1'b0;
    pulse(8'hfa);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h9b);
    // Counter overflow races the clearing write; the set must survive
    apb(1'b1, ba(`IDX_FLAGS_TWO), 8'h00, 8'h02);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h01);
    f8_mode   <= 1'b1;
    conv_busy <= 1'b1;
    @(posedge pclk);
    conv_busy <= 1'b0;
    pulse(8'h14);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h47);
    // Ones keep the conversion and timer C flags, zeros clear the rest
    wr(`IDX_FLAGS_TWO, 8'h42);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h42);
  endtask

  task automatic s_irq();
    wr(`IDX_MASK_TWO, 8'h40);
    repeat (2) @(posedge pclk);
    cmp_bit("irq_out", 1'b1, irq_out);
    wr(`IDX_MASK_TWO, 8'h00);
    repeat (2) @(posedge pclk);
    cmp_bit("irq_out", 1'b0, irq_out);
    wr(`IDX_MASK_TWO, 8'h40);
    wr(`IDX_FLAGS_TWO, 8'h00);
    repeat (2) @(posedge pclk);
    cmp_bit("irq_out", 1'b0, irq_out);
    chk_reg("flags_two", `IDX_FLAGS_TWO, 8'h00);
  endtask

  task automatic s_clear();
    pulse(8'h01);
    wr(`IDX_FLAGS_ONE, 8'h00);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'ha0);
    wr(`IDX_MASK_ONE, 8'h80);
    repeat (2) @(posedge pclk);
    cmp_bit("irq_out", 1'b1, irq_out);
    wr(`IDX_FLAGS_ONE, 8'h80);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'ha0);
    apb(1'b1, ba(`IDX_FLAGS_ONE), 8'h00, 8'h01);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'ha0);
    wr(`IDX_FLAGS_ONE, 8'h00);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h20);
    repeat (2) @(posedge pclk);
    cmp_bit("irq_out", 1'b0, irq_out);
  endtask

  task automatic s_pins();
    wr(`IDX_PORT_B_FUNC, 8'h00);
    wr(`IDX_EDGE_SELECT, 8'h00);
    pins(5'h00);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h20);
    pins(5'h1f);
    wr(`IDX_PORT_B_FUNC, 8'h08);
    wr(`IDX_PIN_ENABLE, 8'h1d);
    cmp_bit("analog_ch3_select", 1'b0, analog_ch3_select);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h20);
    pins(5'h00);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h3f);
    wr(`IDX_FLAGS_ONE, 8'h00);
    wr(`IDX_EDGE_SELECT, 8'h9b);
    pins(5'h1f);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h3f);
    wr(`IDX_FLAGS_ONE, 8'h00);
    pins(5'h00);
    chk_reg("flags_one", `IDX_FLAGS_ONE, 8'h20);
    cmp_byte("timer c pulses", 8'd2, 8'(cnt_c));
    cmp_byte("timer f pulses", 8'd3, 8'(cnt_f));
    cmp_byte("trigger pulses", 8'd3, 8'(cnt_t));
  endtask

  // Reset for ten cycles, then run every scenario in turn
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    strobe_cmd = 8'h00;
    pin_cmd    = 5'h1f;
    conv_busy  = 1'b0;
    f8_mode    = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_strobes();
    s_irq();
    s_clear();
    s_pins();
    complete_run();
  end
endmodule // tb_irq_flag_logic
`default_nettype wire

// ===== rtl/irq_flag_logic.sv
// Interrupt request flag registers, edge selection and APB register slave
//
// Contract
// RULE1: Each pin edge bit picks falling (0) or rising (1); shared inputs follow.
// RULE2: Pins one and zero set their flag on the selected edge when enabled.
// RULE3: Event counter pin sets its flag on its selected edge when enabled.
// RULE4: Pins four and three set their flag on the selected edge when enabled.
// RULE5: Timer A wrap from maximum to zero sets its flag.
// RULE6: A flag clears only on writing 0 after it was read as 1.
// RULE7: Software writes only 0 to flag register one bits 7 and 4..0.
// RULE8: Event counter overflow sets its flag.
// RULE9: Timer C overflow or underflow sets its flag.
// RULE10: Timer F low compare match in 8-bit mode sets its flag.
// RULE11: Port B pin 3 function bit: 0 general/analog input, 1 interrupt pin one.
// RULE12: Software writes only 0 to flag register two bits 7, 6, 4..0.
// RULE13: Conversion done with start flag back at 0 sets the conversion flag.
// RULE14: Writing 1 leaves a flag alone; a set in the clearing cycle wins.
//
// Local design decision: the APB register port.
`include "irq_flag_regs.svh"
`default_nettype none
module irq_flag_logic
  import irq_flag_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_pin0,
  input  wire logic        port_b_pin3,
  input  wire logic        irq_pin3,
  input  wire logic        irq_pin4,
  input  wire logic        event_counter_irq_pin,
  input  wire logic        timer_a_overflow,
  input  wire logic        event_counter_overflow,
  input  wire logic        timer_c_overflow,
  input  wire logic        timer_c_underflow,
  input  wire logic        timer_f_low_match,
  input  wire logic        timer_f_8bit_mode,
  input  wire logic        timer_f_high_match,
  input  wire logic        timer_g_event,
  input  wire logic        conversion_start_flag,
  input  wire logic        direct_transition,
  output var  logic        analog_ch3_select,
  output var  logic        timer_c_event_input,
  output var  logic        timer_f_event_input,
  output var  logic        conversion_trigger_input,
  output var  logic        irq_out
);
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  reg_sel_t sel;
  logic     aligned;
  logic     wr_en;
  logic     rd_en;
  logic     setup;

  // Word aligned, upper bits zero; the index sits in paddr[9:2]
  assign aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  always_comb begin
    sel = SEL_NONE;
    if (aligned) begin
      case (paddr[9:2])
        `IDX_PORT_B_FUNC: sel = SEL_PORT_B;
        `IDX_EDGE_SELECT: sel = SEL_EDGE;
        `IDX_FLAGS_ONE:   sel = SEL_FLAGS_ONE;
        `IDX_FLAGS_TWO:   sel = SEL_FLAGS_TWO;
        `IDX_MASK_ONE:    sel = SEL_MASK_ONE;
        `IDX_MASK_TWO:    sel = SEL_MASK_TWO;
        `IDX_PIN_ENABLE:  sel = SEL_PIN_ENA;
        default:          sel = SEL_NONE;
      endcase
    end
  end

  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == SEL_NONE);
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & (sel != SEL_NONE);
  assign rd_en   = psel & penable & ~pwrite & (sel != SEL_NONE);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg8_t port_b_q, port_b_d;
  reg8_t edge_q, edge_d;
  reg8_t mask_one_q, mask_one_d;
  reg8_t mask_two_q, mask_two_d;
  reg8_t pin_ena_q, pin_ena_d;

  // Writes take effect at the access-phase edge only
  always_comb begin
    port_b_d   = port_b_q;
    edge_d     = edge_q;
    mask_one_d = mask_one_q;
    mask_two_d = mask_two_q;
    pin_ena_d  = pin_ena_q;
    if (wr_en) begin
      case (sel)
        SEL_PORT_B:   port_b_d[`BIT_PIN1_FUNC] = pwdata[`BIT_PIN1_FUNC]; // RULE11
        SEL_EDGE:     edge_d = pwdata[7:0] & `EDGE_SEL_MASK;
        SEL_MASK_ONE: mask_one_d = pwdata[7:0] & `FLAGS_ONE_MASK;
        SEL_MASK_TWO: mask_two_d = pwdata[7:0] & `FLAGS_TWO_MASK;
        SEL_PIN_ENA:  pin_ena_d = pwdata[7:0];
        default:      port_b_d = port_b_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_q   <= `RESET_BYTE;
      edge_q     <= `RESET_BYTE;
      mask_one_q <= `RESET_BYTE;
      mask_two_q <= `RESET_BYTE;
      pin_ena_q  <= `RESET_BYTE;
    end else begin
      port_b_q   <= port_b_d;
      edge_q     <= edge_d;
      mask_one_q <= mask_one_d;
      mask_two_q <= mask_two_d;
      pin_ena_q  <= pin_ena_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  logic [4:0] pins;
  logic [4:0] rising;
  logic [4:0] edges;

  // Port B pin 3 is both the analog input and the interrupt pin one source
  assign pins   = {event_counter_irq_pin, irq_pin4, irq_pin3, port_b_pin3, irq_pin0};
  assign rising = {edge_q[`BIT_EDGE_EVENT], edge_q[`BIT_EDGE_PIN4], edge_q[`BIT_EDGE_PIN3],
                   edge_q[`BIT_EDGE_PIN1], edge_q[`BIT_EDGE_PIN0]}; // RULE1

  pin_edge_detect #(
    .N (5)
  ) u_edges (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (pins),
    .rising_sel (rising),
    .edge_pulse (edges)
  );

  logic pin1_irq_mode;
  assign pin1_irq_mode = port_b_q[`BIT_PIN1_FUNC]; // RULE11

  // ----------------------------------------------------------------
  // Conversion done: start flag falling back to 0
  // ----------------------------------------------------------------
  logic conv_busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy_q <= 1'b0;
    end else begin
      conv_busy_q <= conversion_start_flag;
    end
  end

  // ----------------------------------------------------------------
  // Set events for both flag registers
  // ----------------------------------------------------------------
  reg8_t set_one, set_two;
  always_comb begin
    set_one = `RESET_BYTE;
    set_two = `RESET_BYTE;
    set_one[`BIT_F1_PIN0]      = edges[0] & pin_ena_q[`BIT_ENA_PIN0];   // RULE2
    set_one[`BIT_F1_PIN1]      = edges[1] & pin1_irq_mode;              // RULE2
    set_one[`BIT_F1_EVENT_PIN] = edges[4] & pin_ena_q[`BIT_ENA_EVENT];  // RULE3
    set_one[`BIT_F1_PIN3]      = edges[2] & pin_ena_q[`BIT_ENA_PIN3];   // RULE4
    set_one[`BIT_F1_PIN4]      = edges[3] & pin_ena_q[`BIT_ENA_PIN4];   // RULE4
    set_one[`BIT_F1_TIMER_A]   = timer_a_overflow;                      // RULE5
    set_two[`BIT_F2_EVT_CNT]   = event_counter_overflow;                // RULE8
    set_two[`BIT_F2_TIMER_C]   = timer_c_overflow | timer_c_underflow;  // RULE9
    set_two[`BIT_F2_TIMER_FL]  = timer_f_low_match & timer_f_8bit_mode; // RULE10
    set_two[`BIT_F2_TIMER_FH]  = timer_f_high_match;
    set_two[`BIT_F2_TIMER_G]   = timer_g_event;
    set_two[`BIT_F2_CONV]      = conv_busy_q & ~conversion_start_flag;  // RULE13
    set_two[`BIT_F2_DIRECT]    = direct_transition;
  end

  // ----------------------------------------------------------------
  // Flag registers with read-then-write-0 clearing
  // ----------------------------------------------------------------
  reg8_t flags_one_q, flags_one_d, armed_one_q, armed_one_d, clr_one;
  reg8_t flags_two_q, flags_two_d, armed_two_q, armed_two_d, clr_two;

  // A bit is armed once software has read it as 1; only armed bits clear.
  // Arming uses the byte actually returned (captured in setup), so a flag that
  // sets between setup and access is never cleared without software seeing it.
  always_comb begin
    clr_one = `RESET_BYTE;
    clr_two = `RESET_BYTE;
    if (wr_en && sel == SEL_FLAGS_ONE) begin
      clr_one = ~pwdata[7:0] & armed_one_q & `FLAGS_ONE_MASK; // RULE6 RULE7
    end
    if (wr_en && sel == SEL_FLAGS_TWO) begin
      clr_two = ~pwdata[7:0] & armed_two_q & `FLAGS_TWO_MASK; // RULE6 RULE12
    end
    flags_one_d = (flags_one_q & ~clr_one) | set_one; // RULE14
    flags_two_d = (flags_two_q & ~clr_two) | set_two; // RULE14
    armed_one_d = armed_one_q & ~clr_one;
    armed_two_d = armed_two_q & ~clr_two;
    if (rd_en && sel == SEL_FLAGS_ONE) begin
      armed_one_d = armed_one_d | (prdata[7:0] & `FLAGS_ONE_MASK); // RULE6
    end
    if (rd_en && sel == SEL_FLAGS_TWO) begin
      armed_two_d = armed_two_d | (prdata[7:0] & `FLAGS_TWO_MASK); // RULE6
    end
    armed_one_d = armed_one_d & flags_one_d;
    armed_two_d = armed_two_d & flags_two_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_one_q <= `RESET_BYTE;
      flags_two_q <= `RESET_BYTE;
      armed_one_q <= `RESET_BYTE;
      armed_two_q <= `RESET_BYTE;
    end else begin
      flags_one_q <= flags_one_d;
      flags_two_q <= flags_two_d;
      armed_one_q <= armed_one_d;
      armed_two_q <= armed_two_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  // Capturing in setup gives the access phase a flop-driven prdata
  always_comb begin
    rdata_d = prdata;
    if (setup && !pwrite) begin
      case (sel)
        SEL_PORT_B:    rdata_d = {24'h0, port_b_q | `PORT_B_FIXED};
        SEL_EDGE:      rdata_d = {24'h0, edge_q | `EDGE_SEL_FIXED};
        SEL_FLAGS_ONE: rdata_d = {24'h0, flags_one_q | `FLAGS_ONE_FIXED};
        SEL_FLAGS_TWO: rdata_d = {24'h0, flags_two_q};
        SEL_MASK_ONE:  rdata_d = {24'h0, mask_one_q};
        SEL_MASK_TWO:  rdata_d = {24'h0, mask_two_q};
        SEL_PIN_ENA:   rdata_d = {24'h0, pin_ena_q};
        default:       rdata_d = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs: shared inputs, analog select and interrupt line
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                   <= 32'h0;
      analog_ch3_select        <= 1'b1;
      timer_c_event_input      <= 1'b0;
      timer_f_event_input      <= 1'b0;
      conversion_trigger_input <= 1'b0;
      irq_out                  <= 1'b0;
    end else begin
      prdata                   <= rdata_d;
      analog_ch3_select        <= ~port_b_d[`BIT_PIN1_FUNC]; // RULE11
      timer_c_event_input      <= edges[1] & pin1_irq_mode;  // RULE1
      timer_f_event_input      <= edges[2];                  // RULE1
      conversion_trigger_input <= edges[3];                  // RULE1
      irq_out                  <= |((flags_one_d & mask_one_d) | (flags_two_d & mask_two_d));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_timer_a_set: assert property (timer_a_overflow |=> flags_one_q[`BIT_F1_TIMER_A]) // RULE5
    else $error("timer A flag not set");
  a_timer_c_set: assert property ((timer_c_overflow || timer_c_underflow)
    |=> flags_two_q[`BIT_F2_TIMER_C]) // RULE9
    else $error("timer C flag not set");
  a_fl_mode_gate: assert property ((timer_f_low_match && !timer_f_8bit_mode && !flags_two_q[`BIT_F2_TIMER_FL])
    |=> !flags_two_q[`BIT_F2_TIMER_FL]) // RULE10
    else $error("timer F low flag set outside 8-bit mode");
  a_evt_cnt_set: assert property (event_counter_overflow |=> flags_two_q[`BIT_F2_EVT_CNT]) // RULE8
    else $error("event counter flag not set");
  a_conv_done_set: assert property ($fell(conversion_start_flag) |=> flags_two_q[`BIT_F2_CONV]) // RULE13
    else $error("conversion flag not set");
  a_clear_needs_read: assert property ((flags_one_q[`BIT_F1_PIN0] && !armed_one_q[`BIT_F1_PIN0])
    |=> flags_one_q[`BIT_F1_PIN0]) // RULE6
    else $error("flag cleared without prior read");
  a_write_one_keeps: assert property ((wr_en && sel == SEL_FLAGS_TWO && pwdata[`BIT_F2_TIMER_C]
    && flags_two_q[`BIT_F2_TIMER_C]) |=> flags_two_q[`BIT_F2_TIMER_C]) // RULE14
    else $error("write of 1 disturbed a flag");
  a_set_beats_clear: assert property ((clr_one[`BIT_F1_TIMER_A] && timer_a_overflow)
    |=> flags_one_q[`BIT_F1_TIMER_A]) // RULE14
    else $error("set lost against clear");
  a_pin0_edge_set: assert property ((edges[0] && pin_ena_q[`BIT_ENA_PIN0])
    |=> flags_one_q[`BIT_F1_PIN0]) // RULE2
    else $error("pin zero flag not set");
  a_pin1_mode_gate: assert property ((!pin1_irq_mode && !flags_one_q[`BIT_F1_PIN1])
    ##1 !pin1_irq_mode |-> !flags_one_q[`BIT_F1_PIN1]) // RULE11
    else $error("pin one flag set in analog mode");
  a_event_pin_set: assert property ((edges[4] && pin_ena_q[`BIT_ENA_EVENT])
    |=> flags_one_q[`BIT_F1_EVENT_PIN]) // RULE3
    else $error("event pin flag not set");
  a_pin4_set: assert property ((edges[3] && pin_ena_q[`BIT_ENA_PIN4]) |=> flags_one_q[`BIT_F1_PIN4]) // RULE4
    else $error("pin four flag not set");
  a_fall_edge_sel: assert property ((!rising[0] && $fell(u_edges.g_pin[0].sync_q))
    |=> edges[0]) // RULE1
    else $error("falling edge missed");

  c_read_clear: cover property (rd_en && sel == SEL_FLAGS_ONE ##[1:20] (clr_one != 8'h00));
  c_irq_raise: cover property ($rose(irq_out));
  c_set_clear_race: cover property ((clr_two != 8'h00) && (set_two & clr_two) != 8'h00);
endmodule // irq_flag_logic
`default_nettype wire

// ===== rtl/irq_flag_pkg.sv
// Types shared by the interrupt flag block
`default_nettype none
package irq_flag_pkg;
  typedef logic [7:0] reg8_t;
  // One-hot decode of the register under access
  typedef enum logic [7:0] {
    SEL_NONE      = 8'h00,
    SEL_PORT_B    = 8'h01,
    SEL_EDGE      = 8'h02,
    SEL_FLAGS_ONE = 8'h04,
    SEL_FLAGS_TWO = 8'h08,
    SEL_MASK_ONE  = 8'h10,
    SEL_MASK_TWO  = 8'h20,
    SEL_PIN_ENA   = 8'h40
  } reg_sel_t;
endpackage
`default_nettype wire

// ===== rtl/irq_flag_regs.svh
// Register indices, bit positions and reset values of the interrupt flag block
`ifndef IRQ_FLAG_REGS_SVH
`define IRQ_FLAG_REGS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PORT_B_FUNC   8'hee
`define IDX_EDGE_SELECT   8'hf2
`define IDX_FLAGS_ONE     8'hf6
`define IDX_FLAGS_TWO     8'hf7
`define IDX_MASK_ONE      8'hf8
`define IDX_MASK_TWO      8'hf9
`define IDX_PIN_ENABLE    8'hfa
// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define BIT_PIN1_FUNC     3
`define BIT_EDGE_PIN0     0
`define BIT_EDGE_PIN1     1
`define BIT_EDGE_PIN3     3
`define BIT_EDGE_PIN4     4
`define BIT_ENA_PIN0      0
`define BIT_ENA_EVENT     2
`define BIT_ENA_PIN3      3
`define BIT_ENA_PIN4      4
`define BIT_EDGE_EVENT    7
`define BIT_F1_TIMER_A    7
`define BIT_F1_PIN4       4
`define BIT_F1_PIN3       3
`define BIT_F1_EVENT_PIN  2
`define BIT_F1_PIN1       1
`define BIT_F1_PIN0       0
`define BIT_F2_DIRECT     7
`define BIT_F2_CONV       6
`define BIT_F2_TIMER_G    4
`define BIT_F2_TIMER_FH   3
`define BIT_F2_TIMER_FL   2
`define BIT_F2_TIMER_C    1
`define BIT_F2_EVT_CNT    0
// ----------------------------------------------------------------
// Writable masks, fixed read bits and reset values
// ----------------------------------------------------------------
`define FLAGS_ONE_MASK    8'h9f
`define FLAGS_TWO_MASK    8'hdf
`define FLAGS_ONE_FIXED   8'h20
`define PORT_B_FIXED      8'hf7
`define EDGE_SEL_MASK     8'h9b
`define EDGE_SEL_FIXED    8'h64
`define RESET_BYTE        8'h00
`endif

// ===== rtl/pin_edge_detect.sv
// Synchroniser and selectable edge detector for the external interrupt pins
`default_nettype none
module pin_edge_detect
  import irq_flag_pkg::*;
#(
  parameter int N = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] pin_in,
  input  wire logic [N-1:0] rising_sel,
  output var  logic [N-1:0] edge_pulse
);
  // ----------------------------------------------------------------
  // Per-pin synchroniser, history and detector
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic meta_q, sync_q, prev_q, pulse_q;
    logic pulse_d;
    // Only sync_q and prev_q are compared; meta_q feeds nothing else
    always_comb begin
      pulse_d = rising_sel[i] ? (sync_q & ~prev_q) : (~sync_q & prev_q); // RULE1
    end
    // Pins idle high, so history resets high to avoid a false falling edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q  <= 1'b1;
        sync_q  <= 1'b1;
        prev_q  <= 1'b1;
        pulse_q <= 1'b0;
      end else begin
        meta_q  <= pin_in[i];
        sync_q  <= meta_q;
        prev_q  <= sync_q;
        pulse_q <= pulse_d;
      end
    end
    assign edge_pulse[i] = pulse_q;
  end
endmodule // pin_edge_detect
`default_nettype wire
